// ==== rtl/btprs_pkg.sv ====
/*
  Constants for the radio power and reset sequencer.
  Assumes a single 200 MHz core clock and a slow oscillator sampled as a level.
*/
// What this block does
// - The baseband core pulses the transmit and receive enables only inside each packet.
// - In sniff or hold the block counts slow oscillator ticks and wakes after a set interval.
// - In shutdown the radio and core supplies are off while the io supply stays on.
// - In shutdown every output enable is low and most input receivers are disabled.
// - Leaving shutdown runs the full cold power-up and keeps no earlier state.
// - The broadcast receiver is either fully on or fully off and follows the radio power.
// - All radio core logic is held in reset while the power enable input is low.
// - An asserted device wake input keeps the device out of sleep and ends shutdown with a cold start; its polarity is selectable.
// - The device asserts host wake when it needs the host; its polarity is selectable.
package btprs_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] BTPRS_REG_CTRL   = 4'h0;
  localparam logic [3:0] BTPRS_REG_SLEEP  = 4'h1;
  localparam logic [3:0] BTPRS_REG_STATUS = 4'h2;
  localparam logic [3:0] BTPRS_REG_IRQ    = 4'h3;
  localparam logic [3:0] BTPRS_REG_MASK   = 4'h4;
  localparam logic [3:0] BTPRS_REG_PKT    = 4'h5;
  // ==========================================================
  // Control bits
  localparam int BTPRS_CTRL_SHUTDOWN = 0;
  localparam int BTPRS_CTRL_FM_ON    = 1;
  localparam int BTPRS_CTRL_DW_POL   = 2;
  localparam int BTPRS_CTRL_HW_POL   = 3;
  localparam int BTPRS_CTRL_HW_REQ   = 4;
  localparam int BTPRS_CTRL_SLEEP    = 5;
  localparam logic [5:0] BTPRS_CTRL_RST = 6'h00;
  // Interrupt bits: wake by timer, wake by host, power up done
  localparam int BTPRS_IRQ_TIMER = 0;
  localparam int BTPRS_IRQ_HOST  = 1;
  localparam int BTPRS_IRQ_UP    = 2;
  // ==========================================================
  // Timing
  localparam int BTPRS_CLK_MHZ      = 200;
  localparam int BTPRS_PWR_SETTLE_NS = 1000;
  localparam int BTPRS_PWR_SETTLE_CYC = (BTPRS_PWR_SETTLE_NS * BTPRS_CLK_MHZ + 999) / 1000;
  localparam logic [15:0] BTPRS_SLEEP_RST = 16'h0020;
  typedef enum logic [2:0] {
    BTPRS_OFF, BTPRS_POWER_UP, BTPRS_ACTIVE, BTPRS_SLEEP, BTPRS_SHUTDOWN
  } btprs_state_t;
endpackage

// ==== rtl/btprs_top.sv ====
/*
  Radio power state and reset sequencer.
  Assumes all inputs are synchronous to core_clk; slow_oscillator_input is a sampled level.
*/
`timescale 1ns/1ps
module btprs_top
  import btprs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        radio_core_power_enable,
  input  wire logic        device_wake_request,
  input  wire logic        slow_oscillator_input,
  input  wire logic        pkt_active,
  input  wire logic        pkt_is_tx,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  output logic             host_wake_request,
  output logic             host_wake_oe,
  output logic             tx_enable,
  output logic             rx_enable,
  output logic             core_supply_on,
  output logic             rf_supply_on,
  output logic             core_resetn,
  output logic             fm_power_on,
  output logic             input_enable,
  output logic             slow_clk_select
);
  // ==========================================================
  // State
  btprs_state_t st_q, st_d;
  logic [5:0]  ctrl_q, ctrl_d;
  logic [15:0] sleep_q, sleep_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0]  irq_q, irq_d;
  logic [2:0]  mask_q, mask_d;
  logic        osc_q, osc_d;
  logic [31:0] rdata_d;
  logic        txe_d, rxe_d, hw_d, hwoe_d, core_d, rf_d, crst_d, fm_d, ie_d, slw_d, irqo_d;
  logic        hold, dev_wake, tick, pwr_ok, up_done;
  logic [2:0]  ev;

  // Reset held by power enable low
  assign hold     = !resetn || !radio_core_power_enable;
  assign dev_wake = device_wake_request ^ ctrl_q[BTPRS_CTRL_DW_POL];
  assign tick     = slow_oscillator_input && !osc_q;
  assign pwr_ok   = (cnt_q >= 16'(BTPRS_PWR_SETTLE_CYC));

  // ==========================================================
  // Sequencer next state
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    up_done = 1'b0;
    ev      = 3'h0;
    case (st_q)
      BTPRS_OFF: begin
        st_d  = BTPRS_POWER_UP;
        cnt_d = 16'h0000;
      end
      BTPRS_POWER_UP: begin
        cnt_d = cnt_q + 16'h0001;
        if (pwr_ok) begin
          st_d    = BTPRS_ACTIVE;
          up_done = 1'b1;
        end
      end
      BTPRS_ACTIVE: begin
        if (ctrl_q[BTPRS_CTRL_SHUTDOWN]) begin
          st_d = BTPRS_SHUTDOWN;
        end else if (ctrl_q[BTPRS_CTRL_SLEEP] && !dev_wake && !pkt_active) begin
          st_d  = BTPRS_SLEEP;
          cnt_d = 16'h0000;
        end
      end
      BTPRS_SLEEP: begin
        if (dev_wake) begin
          st_d  = BTPRS_ACTIVE;
          ev[BTPRS_IRQ_HOST] = 1'b1;
        end else if (tick) begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q + 16'h0001 >= sleep_q) begin
            st_d = BTPRS_ACTIVE;
            ev[BTPRS_IRQ_TIMER] = 1'b1;
          end
        end
      end
      BTPRS_SHUTDOWN: begin
        // Only a cold restart leaves; nothing survives
        if (!ctrl_q[BTPRS_CTRL_SHUTDOWN] || dev_wake) begin
          st_d  = BTPRS_OFF;
        end
      end
      default: st_d = BTPRS_OFF;
    endcase
    if (up_done) ev[BTPRS_IRQ_UP] = 1'b1;
  end

  // ==========================================================
  // Registers, write side; set wins over write-one-to-clear
  always_comb begin
    ctrl_d  = ctrl_q;
    sleep_d = sleep_q;
    mask_d  = mask_q;
    irq_d   = irq_q;
    if (reg_wr) begin
      case (reg_addr)
        BTPRS_REG_CTRL:  ctrl_d  = reg_wdata[5:0];
        BTPRS_REG_SLEEP: sleep_d = reg_wdata[15:0];
        BTPRS_REG_IRQ:   irq_d   = irq_q & ~reg_wdata[2:0];
        BTPRS_REG_MASK:  mask_d  = reg_wdata[2:0];
        default: ;
      endcase
    end
    irq_d = irq_d | ev;
    // Sleep request is one-shot so a wake does not re-enter at once
    if (st_q == BTPRS_SLEEP) ctrl_d[BTPRS_CTRL_SLEEP] = 1'b0;
    // Cold start forgets every setting and pending event, not just the mode bits
    if (st_q == BTPRS_OFF) begin
      ctrl_d  = BTPRS_CTRL_RST;
      sleep_d = BTPRS_SLEEP_RST;
      mask_d  = 3'h0;
      irq_d   = 3'h0;
    end
  end

  // ==========================================================
  // Read mux and outputs
  always_comb begin
    case (reg_addr)
      BTPRS_REG_CTRL:   rdata_d = {26'h0, ctrl_q};
      BTPRS_REG_SLEEP:  rdata_d = {16'h0, sleep_q};
      BTPRS_REG_STATUS: rdata_d = {27'h0, dev_wake, 1'b0, st_q};
      BTPRS_REG_IRQ:    rdata_d = {29'h0, irq_q};
      BTPRS_REG_MASK:   rdata_d = {29'h0, mask_q};
      default:          rdata_d = 32'h0;
    endcase
    if (!reg_rd) rdata_d = 32'h0;
    core_d = (st_q == BTPRS_POWER_UP) || (st_q == BTPRS_ACTIVE) || (st_q == BTPRS_SLEEP);
    rf_d   = (st_q == BTPRS_ACTIVE);
    crst_d = (st_d == BTPRS_ACTIVE) || (st_d == BTPRS_SLEEP);
    txe_d  = rf_d && (st_d == BTPRS_ACTIVE) && pkt_active && pkt_is_tx;
    rxe_d  = rf_d && (st_d == BTPRS_ACTIVE) && pkt_active && !pkt_is_tx;
    fm_d   = rf_d && ctrl_q[BTPRS_CTRL_FM_ON];
    slw_d  = (st_q == BTPRS_SLEEP);
    ie_d   = (st_q != BTPRS_SHUTDOWN);
    hwoe_d = (st_q != BTPRS_SHUTDOWN) && (st_q != BTPRS_OFF);
    hw_d   = hwoe_d && ((ctrl_q[BTPRS_CTRL_HW_REQ] || |(irq_q & mask_q))
             ^ ctrl_q[BTPRS_CTRL_HW_POL]);
    irqo_d = |(irq_d & mask_d);
    osc_d  = slow_oscillator_input;
  end

  // Registered state; power enable low forces a cold start
  always_ff @(posedge core_clk) begin
    if (hold) begin
      st_q  <= BTPRS_OFF;
      cnt_q <= 16'h0000;
      ctrl_q <= BTPRS_CTRL_RST;
      sleep_q <= BTPRS_SLEEP_RST;
      irq_q <= 3'h0;
      mask_q <= 3'h0;
      osc_q <= 1'b0;
      reg_rdata <= 32'h0;
      irq <= 1'b0;
      host_wake_request <= 1'b0;
      host_wake_oe <= 1'b0;
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
      core_supply_on <= 1'b0;
      rf_supply_on <= 1'b0;
      core_resetn <= 1'b0;
      fm_power_on <= 1'b0;
      input_enable <= 1'b0;
      slow_clk_select <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      sleep_q <= sleep_d;
      irq_q <= irq_d;
      mask_q <= mask_d;
      osc_q <= osc_d;
      reg_rdata <= rdata_d;
      irq <= irqo_d;
      host_wake_request <= hw_d;
      host_wake_oe <= hwoe_d;
      tx_enable <= txe_d;
      rx_enable <= rxe_d;
      core_supply_on <= core_d;
      rf_supply_on <= rf_d;
      core_resetn <= crst_d;
      fm_power_on <= fm_d;
      input_enable <= ie_d;
      slow_clk_select <= slw_d;
    end
  end

  // ==========================================================
  // Assertion helpers
  // Independent count of power-up cycles, so the settle check does not
  // reuse the sequencer's own counter
  logic [15:0] up_len_q, up_len_d;
  logic        st_up, st_off, st_act, st_slp, st_sd;

  // State decodes shared by the checks below
  assign st_up  = (st_q == BTPRS_POWER_UP);
  assign st_off = (st_q == BTPRS_OFF);
  assign st_act = (st_q == BTPRS_ACTIVE);
  assign st_slp = (st_q == BTPRS_SLEEP);
  assign st_sd  = (st_q == BTPRS_SHUTDOWN);

  // Power-up length, cleared outside power-up
  always_comb begin
    up_len_d = st_up ? (up_len_q + 16'h0001) : 16'h0000;
  end

  // Helper register; cleared with the rest of the core
  always_ff @(posedge core_clk) begin
    if (hold) begin
      up_len_q <= 16'h0000;
    end else begin
      up_len_q <= up_len_d;
    end
  end

  // Cold start steps: off for one cycle, then power-up with clean registers
  sequence s_cold_off;
    st_off;
  endsequence
  sequence s_cold_up;
    st_up && (ctrl_q == BTPRS_CTRL_RST) && (sleep_q == BTPRS_SLEEP_RST)
      && (mask_q == 3'h0) && (irq_q == 3'h0);
  endsequence

  // Shutdown steps: request seen, state taken, then pins released
  sequence s_sd_enter;
    st_act && ctrl_q[BTPRS_CTRL_SHUTDOWN];
  endsequence
  sequence s_sd_off;
    st_sd ##1 (!rf_supply_on && !input_enable && !host_wake_oe);
  endsequence

  // ==========================================================
  // Checks
  a_reset_hold: assert property (@(posedge core_clk)
    !radio_core_power_enable |=> !core_resetn && !rf_supply_on)
    else $error("core not held in reset while power enable low");
  a_shutdown_tristate: assert property (@(posedge core_clk) disable iff (hold)
    st_q == BTPRS_SHUTDOWN |=> !host_wake_oe && !input_enable && !core_supply_on)
    else $error("outputs driven in shutdown");
  a_rf_off_down: assert property (@(posedge core_clk) disable iff (hold)
    st_q == BTPRS_SHUTDOWN |=> !rf_supply_on && !fm_power_on)
    else $error("rf supply on in shutdown");
  a_txrx_packet: assert property (@(posedge core_clk) disable iff (hold)
    !pkt_active |=> !tx_enable && !rx_enable)
    else $error("rf path enabled outside packet");
  a_wake_exit: assert property (@(posedge core_clk) disable iff (hold)
    st_q == BTPRS_SLEEP && dev_wake |=> st_q == BTPRS_ACTIVE)
    else $error("sleep not left on device wake");
  a_sleep_entry: assert property (@(posedge core_clk) disable iff (hold)
    $rose(st_q == BTPRS_SLEEP) |-> $past(!dev_wake))
    else $error("sleep entered with device wake asserted");
  a_slow_clk: assert property (@(posedge core_clk) disable iff (hold)
    st_q == BTPRS_SLEEP |=> slow_clk_select)
    else $error("slow clock not selected in sleep");
  a_fm_follow: assert property (@(posedge core_clk) disable iff (hold)
    fm_power_on |-> rf_supply_on)
    else $error("fm on without radio power");
  a_cold_start: assert property (@(posedge core_clk) disable iff (hold)
    st_q == BTPRS_OFF |=> st_q == BTPRS_POWER_UP && ctrl_q[BTPRS_CTRL_SHUTDOWN] == 1'b0)
    else $error("restart kept old state");
  a_host_wake_pol: assert property (@(posedge core_clk) disable iff (hold)
    host_wake_oe && ctrl_q[BTPRS_CTRL_HW_REQ] && $stable(ctrl_q) && $stable(host_wake_oe)
    |-> host_wake_request == !ctrl_q[BTPRS_CTRL_HW_POL])
    else $error("host wake level wrong");
  // Power-up must last the full settle time before release
  a_settle_len: assert property (@(posedge core_clk) disable iff (hold)
    $fell(st_up) && st_act |-> $past(up_len_q) >= 16'(BTPRS_PWR_SETTLE_CYC))
    else $error("core released before supplies settled");
  // Any hold, reset or power enable, silences the outputs one edge later
  a_hold_outputs: assert property (@(posedge core_clk)
    hold |=> !core_supply_on && !core_resetn && !host_wake_oe && !irq)
    else $error("outputs active while core held");
  // Nothing written before shutdown survives a cold start
  a_cold_clear: assert property (@(posedge core_clk) disable iff (hold)
    s_cold_off |=> s_cold_up)
    else $error("registers kept over cold start");
  // Shutdown request leads to released pins in two steps
  a_shutdown_steps: assert property (@(posedge core_clk) disable iff (hold)
    s_sd_enter |=> s_sd_off)
    else $error("pins not released after shutdown");
  // An asserted device wake keeps the core out of sleep
  a_sleep_blocked: assert property (@(posedge core_clk) disable iff (hold)
    st_act && dev_wake |=> !st_slp)
    else $error("sleep entered against device wake");
endmodule // btprs_top

// ==== dv/btprs_host_model.sv ====
/*
  Host side model: drives the power enable and device wake pins.
  Assumes the bench sets its wishes just after a rising core_clk edge.
*/
`timescale 1ns/1ps
module btprs_host_model (
  input  wire logic core_clk,
  input  wire logic want_power,
  input  wire logic want_wake,
  input  wire logic wake_low,
  output logic      radio_core_power_enable,
  output logic      device_wake_request
);
  // ==========================================================
  // Pins
  // Both pins start low, so the core sits in reset from time zero
  initial begin
    radio_core_power_enable = 1'b0;
    device_wake_request     = 1'b0;
  end
  // One edge late, as a real host pin would be
  always @(posedge core_clk) begin
    radio_core_power_enable <= want_power;
    device_wake_request     <= want_wake ^ wake_low;
  end
endmodule // btprs_host_model

// ==== dv/btprs_tb_top.sv ====
/*
  Self-checking bench for the radio power and reset sequencer.
  Assumes the host model on the pins and the register bus driven here.
*/
`timescale 1ns/1ps
module btprs_tb_top;
  import btprs_pkg::*;
  logic        core_clk = 0, resetn = 0, slow_osc = 0, pkt_active = 0, pkt_is_tx = 0;
  logic        want_power = 0, want_wake = 0, wake_low = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic        power_en, dev_wake, irq, hw, hw_oe, tx_en, rx_en;
  logic        core_on, rf_on, core_rstn, fm_on, in_en, slow_sel, t;
  int          error_cnt = 0, comparisons = 0, cyc = 0, n;
  // ==========================================================
  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  btprs_host_model btprs_host_model_i (.core_clk(core_clk), .want_power(want_power),
    .want_wake(want_wake), .wake_low(wake_low), .radio_core_power_enable(power_en),
    .device_wake_request(dev_wake));
  btprs_top btprs_top_i (.core_clk(core_clk), .resetn(resetn), .radio_core_power_enable(power_en),
    .device_wake_request(dev_wake), .slow_oscillator_input(slow_osc), .pkt_active(pkt_active),
    .pkt_is_tx(pkt_is_tx), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .host_wake_request(hw),
    .host_wake_oe(hw_oe), .tx_enable(tx_en), .rx_enable(rx_en), .core_supply_on(core_on),
    .rf_supply_on(rf_on), .core_resetn(core_rstn), .fm_power_on(fm_on),
    .input_enable(in_en), .slow_clk_select(slow_sel));
  // ==========================================================
  // Helpers
  function automatic logic hw_exp(logic req, logic pend, logic inv);
    return (req | pend) ^ inv;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge core_clk) slow_osc <= 1'b1;
      repeat (4) @(posedge core_clk);
      slow_osc <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // Settle takes 200 cycles, so probe before and after it
  task automatic powerup();
    @(posedge core_clk) want_power <= 1'b1;
    wt(150); rd(BTPRS_REG_STATUS, 32'h1, 32'h7);
    wt(60);  rd(BTPRS_REG_STATUS, 32'h2, 32'h7);
    chk({core_rstn, core_on, rf_on, in_en}, 32'hF);
    rd(BTPRS_REG_IRQ, 32'h4);
  endtask
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(53));
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    powerup();
    rd(4'h5, 32'h0);
    // Random packets gate the radio path
    repeat (6) begin
      @(posedge core_clk) t = 1'($urandom); pkt_is_tx <= t; pkt_active <= 1'b1;
      wt(3); chk({tx_en, rx_en}, {30'h0, t, ~t});
      @(posedge core_clk) pkt_active <= 1'b0;
      wt(3); chk({tx_en, rx_en}, 32'h0);
    end
    wr(BTPRS_REG_MASK, 32'h4); wt(2); chk({irq, hw}, {30'h0, 1'b1, hw_exp(0, 1, 0)});
    wr(BTPRS_REG_IRQ, 32'h4); wt(2); chk({irq, hw}, 32'h0);
    wr(BTPRS_REG_CTRL, 32'h18); wt(2); chk({hw_oe, hw}, {30'h0, 1'b1, hw_exp(1, 0, 1)});
    wr(BTPRS_REG_CTRL, 32'h12); wt(2); chk({fm_on, hw}, 32'h3);
    // Timed sleep on the slow clock
    n = 2 + $urandom % 4;
    wr(BTPRS_REG_SLEEP, n[31:0]); wr(BTPRS_REG_CTRL, 32'h20);
    @(posedge core_clk) pkt_active <= 1'b1;
    wt(3); rd(BTPRS_REG_STATUS, 32'h3, 32'h7);
    chk({slow_sel, tx_en, rx_en}, 32'h4);
    tick(n - 1); rd(BTPRS_REG_STATUS, 32'h3, 32'h7);
    tick(2); pkt_active <= 1'b0; wt(4); rd(BTPRS_REG_STATUS, 32'h2, 32'h7);
    rd(BTPRS_REG_IRQ, 32'h1);
    // Host wake cuts sleep short, then blocks it
    wr(BTPRS_REG_IRQ, 32'h1); wr(BTPRS_REG_CTRL, 32'h20); wt(3);
    @(posedge core_clk) want_wake <= 1'b1;
    wt(5); rd(BTPRS_REG_STATUS, 32'h2, 32'h7); rd(BTPRS_REG_IRQ, 32'h2);
    wr(BTPRS_REG_CTRL, 32'h4); wake_low <= 1'b1;
    wr(BTPRS_REG_CTRL, 32'h24); wt(4); rd(BTPRS_REG_STATUS, 32'h2, 32'h7);
    // Shutdown, then a cold start with nothing kept
    wr(BTPRS_REG_CTRL, 32'h3); wake_low <= 1'b0; want_wake <= 1'b0; wt(4);
    chk({core_on, rf_on}, 32'h0);
    chk({hw_oe, in_en, tx_en, rx_en}, 32'h0);
    chk(fm_on, 32'h0);
    @(posedge core_clk) want_wake <= 1'b1;
    wt(3); want_wake <= 1'b0; powerup(); rd(BTPRS_REG_CTRL, 32'h0);
    rd(BTPRS_REG_MASK, 32'h0);
    rd(BTPRS_REG_SLEEP, {16'h0, BTPRS_SLEEP_RST});
    // Leaving shutdown by clearing the request is a cold start as well
    wr(BTPRS_REG_MASK, 32'h1); wr(BTPRS_REG_CTRL, 32'h1); wt(3);
    chk({core_on, rf_on}, 32'h0);
    wr(BTPRS_REG_CTRL, 32'h0); powerup(); rd(BTPRS_REG_MASK, 32'h0);
    // Losing the power enable mid-run resets the core
    @(posedge core_clk) want_power <= 1'b0;
    wt(3); chk({core_rstn, core_on, rf_on}, 32'h0);
    powerup();
    results();
  end
endmodule // btprs_tb_top
